// >>> logic/servo_scan_pkg.sv
// Purpose: shared constants for the servo scan pwm and alarm block
// Assumes: 40 MHz clock, APB register access, 32-bit data
// Notes:   widths in 0.1 us units, angles in 0.1 degree units
package servo_scan_pkg;
  // clock and timing
  localparam int unsigned CLK_HZ          = 40_000_000;
  localparam int unsigned PWM_RATE_HZ     = 333;
  localparam int unsigned FRAME_CYC       = CLK_HZ / PWM_RATE_HZ;
  // resolution tick 0.7 us, 28 cycles at 40 MHz
  localparam int unsigned RES_TENTH_NS    = 7000;
  localparam int unsigned TICK_CYC        = (CLK_HZ / 1000) * RES_TENTH_NS / 10_000_000;
  // maximum width 3000 us in 0.1 us units
  localparam logic [15:0] WIDTH_MAX       = 16'h7530;
  // reset values
  localparam logic [15:0] MIN_W_RST       = 16'h2710; // 1000.0 us
  localparam logic [15:0] MAX_W_RST       = 16'h4e20; // 2000.0 us
  localparam logic [15:0] SCALE_RST       = 16'h0064; // 10.0 us per degree, 0.1 us units
  localparam logic [15:0] STEPS_RST       = 16'h0004;
  localparam logic [15:0] FOV_LO_RST      = 16'hf8f8; // -180.0 deg
  localparam logic [15:0] FOV_HI_RST      = 16'h0708; // +180.0 deg
  localparam logic [15:0] A_LO_RST        = 16'hfc7c; // -90.0 deg
  localparam logic [15:0] A_HI_RST        = 16'h0000;
  localparam logic [15:0] B_LO_RST        = 16'h0000;
  localparam logic [15:0] B_HI_RST        = 16'h0384; // +90.0 deg
  localparam logic [15:0] DIST_A_RST      = 16'h03e8; // 10.00 m in cm
  localparam logic [15:0] DIST_B_RST      = 16'h01f4; // 5.00 m in cm
  // register byte offsets
  localparam logic [7:0] CTRL_OFS         = 8'h00;
  localparam logic [7:0] STATUS_OFS       = 8'h04;
  localparam logic [7:0] MIN_W_OFS        = 8'h08;
  localparam logic [7:0] MAX_W_OFS        = 8'h0c;
  localparam logic [7:0] SCALE_OFS        = 8'h10;
  localparam logic [7:0] POS_OFS          = 8'h14;
  localparam logic [7:0] STEPS_OFS        = 8'h18;
  localparam logic [7:0] LAG_OFS          = 8'h1c;
  localparam logic [7:0] FOV_LO_OFS       = 8'h20;
  localparam logic [7:0] FOV_HI_OFS       = 8'h24;
  localparam logic [7:0] A_WIN_OFS        = 8'h28;
  localparam logic [7:0] B_WIN_OFS        = 8'h2c;
  localparam logic [7:0] DIST_OFS         = 8'h30;
  localparam logic [7:0] READ_OFS         = 8'h34;
  localparam logic [7:0] WIDTH_OFS        = 8'h38;
  localparam logic [7:0] IRQ_ST_OFS       = 8'h3c;
  localparam logic [7:0] IRQ_MASK_OFS     = 8'h40;
  // control bit positions
  localparam int unsigned CTRL_CONN       = 0;
  localparam int unsigned CTRL_SCAN       = 1;
  localparam int unsigned CTRL_UNI        = 2;
  localparam int unsigned CTRL_MID        = 3;
  // interrupt bit positions
  localparam int unsigned IRQ_READ        = 0;
  localparam int unsigned IRQ_SWEEP       = 1;
  localparam int unsigned IRQ_ALARM       = 2;
endpackage

// >>> logic/servo_scan_pwm_alarms.sv
// Purpose: servo pwm generator, scan sweeper, scan data crop and two alarms
// Assumes: distance readings arrive as a one-cycle strobe from same-clock logic
// Notes:   registers over APB, one level interrupt output
//
// Functional notes
// - pulse width 0..3000 us, 0.7 us steps
// - pulse repeats and refreshes 333 times per second
// - width clamped between lower and upper limits
// - lower limit left, upper limit right
// - midpoint request commands mean of limits
// - angle times scale added to midpoint width
// - scan advances configured steps per reading
// - lag offset corrects reported aiming angle
// - readings outside field of view discarded
// - bi- or uni-directional scan type
// - alarm set when distance below threshold
// - idle alarms re-evaluated every reading
// - scan alarms need distance and angle window
// - scan alarms update only at sweep end
// - field of view defaults -180 to +180
// - steps per reading defaults to four
`timescale 1ns/10ps
module servo_scan_pwm_alarms #(
  parameter int unsigned FRAME_CYC = servo_scan_pkg::FRAME_CYC,
  parameter int unsigned TICK_CYC  = servo_scan_pkg::TICK_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        dist_valid,    // one-cycle strobe, new reading
  input  wire logic [15:0] dist_cm,       // reading in centimetres
  output logic             servo_pwm,
  output logic             alarm_a,
  output logic             alarm_b,
  output logic             read_valid,    // accepted reading strobe
  output logic      [15:0] read_angle,    // corrected angle, 0.1 deg
  output logic      [15:0] read_dist,
  output logic             irq
);
  // package constants under short local names
  localparam int unsigned CTRL_CONN   = servo_scan_pkg::CTRL_CONN;
  localparam int unsigned CTRL_SCAN   = servo_scan_pkg::CTRL_SCAN;
  localparam int unsigned CTRL_UNI    = servo_scan_pkg::CTRL_UNI;
  localparam int unsigned CTRL_MID    = servo_scan_pkg::CTRL_MID;
  localparam logic [15:0] MIN_W_RST_C = servo_scan_pkg::MIN_W_RST;
  localparam logic [15:0] WIDTH_MAX_C = servo_scan_pkg::WIDTH_MAX;
  // settings registers
  logic [3:0]  ctrl_r;
  logic [15:0] min_w_r, max_w_r, scale_r, pos_r, steps_r, lag_r;
  logic [15:0] fov_lo_r, fov_hi_r, a_lo_r, a_hi_r, b_lo_r, b_hi_r;
  logic [15:0] dist_a_r, dist_b_r;
  logic [2:0]  irq_st_r, irq_mask_r;
  // scan state
  logic [15:0] scan_w_r;        // width commanded by the sweep, 0.1 us
  logic        dir_r;           // 1 = moving toward upper limit (right)
  logic        pend_a_r, pend_b_r;
  logic [15:0] width_r;         // width latched for the current frame
  logic [21:0] frame_cnt_r;
  logic [5:0]  tick_cnt_r;
  logic [15:0] hi_ticks_r;
  logic        sweep_end;
  logic        accept;
  logic [15:0] mid_w, pos_w, target_w, step_w, cur_ang, rep_ang;
  logic        hit_a, hit_b;    // reading inside an alarm zone
  logic [2:0]  ev, clr;         // status set and clear

  // apb write strobe: lands at the access edge
  wire wr_en = psel && penable && pwrite;

  // clamp a width into the configured limits, used on two paths
  function automatic logic [15:0] clamp_w(input logic [31:0] w, input logic [15:0] lo,
                                          input logic [15:0] hi);
    logic signed [31:0] s;
    s = $signed(w);
    if (s < $signed({16'h0000, lo})) clamp_w = lo;
    else if (s > $signed({16'h0000, hi})) clamp_w = hi;
    else clamp_w = w[15:0];
  endfunction

  // signed inclusive window test for angles
  function automatic logic in_win(input logic [15:0] a, input logic [15:0] lo,
                                  input logic [15:0] hi);
    in_win = ($signed(a) >= $signed(lo)) && ($signed(a) <= $signed(hi));
  endfunction

  // width arithmetic
  always_comb begin
    logic [31:0] prod;
    logic [31:0] raw;
    prod     = 32'h0;
    raw      = 32'h0;
    mid_w    = 16'(({1'b0, min_w_r} + {1'b0, max_w_r}) >> 1);
    // pos in 0.1 deg, scale in 0.1 us/deg: width offset = pos*scale/10
    prod     = 32'($signed(pos_r) * $signed({1'b0, scale_r}));
    raw      = 32'($signed({16'h0000, mid_w}) + $signed(prod) / 10);
    pos_w    = clamp_w(raw, min_w_r, max_w_r);
    // one step is one 0.7 us tick, 7 in 0.1 us units
    step_w   = 16'(32'(steps_r) * 7);
    if (!ctrl_r[CTRL_CONN]) target_w = 16'h0000;
    else if (ctrl_r[CTRL_SCAN]) target_w = scan_w_r;
    else if (ctrl_r[CTRL_MID]) target_w = mid_w;
    else target_w = pos_w;
  end

  // current angle from sweep width, lag applied against direction of travel
  always_comb begin
    logic signed [31:0] d;
    d       = 32'($signed({16'h0000, scan_w_r}) - $signed({16'h0000, mid_w}));
    // 0.1 deg is ten times the offset over the scale
    cur_ang = (scale_r == 16'h0000) ? 16'h0000 : 16'((d * 10) / $signed({16'h0, scale_r}));
    rep_ang = dir_r ? 16'(cur_ang - lag_r) : 16'(cur_ang + lag_r);
  end

  // a reading is reported during scans only in the active direction and fov
  // uni mode keeps dir_r high, and bi mode skips the direction test
  assign accept = dist_valid && ctrl_r[CTRL_SCAN]
                  && (!ctrl_r[CTRL_UNI] || dir_r)
                  && in_win(rep_ang, fov_lo_r, fov_hi_r);

  // sweep end: reaching a limit on a stepped reading
  // the reading that steps onto a limit ends the sweep
  assign sweep_end = dist_valid && ctrl_r[CTRL_SCAN]
                     && ((dir_r && (32'(scan_w_r) + 32'(step_w) >= 32'(max_w_r)))
                      || (!dir_r && (32'(scan_w_r) <= 32'(min_w_r) + 32'(step_w))));

  // sweep position and direction
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scan_w_r <= MIN_W_RST_C;
      dir_r    <= 1'b1;
    end else if (!ctrl_r[CTRL_SCAN]) begin
      scan_w_r <= min_w_r;
      dir_r    <= 1'b1;
    end else if (dist_valid) begin
      if (dir_r) begin
        scan_w_r <= clamp_w(32'(scan_w_r) + 32'(step_w), min_w_r, max_w_r);
        if (sweep_end) begin
          dir_r <= ctrl_r[CTRL_UNI] ? 1'b1 : 1'b0;
          // the servo slews back unread to the lower limit
          if (ctrl_r[CTRL_UNI]) scan_w_r <= min_w_r; // return to start
        end
      end else begin
        scan_w_r <= clamp_w(32'(scan_w_r) - 32'(step_w), min_w_r, max_w_r);
        if (sweep_end) dir_r <= 1'b1;
      end
    end
  end

  // alarms: direct on each reading when idle, pending and sweep-end when scanning
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      alarm_a  <= 1'b0;
      alarm_b  <= 1'b0;
      pend_a_r <= 1'b0;
      pend_b_r <= 1'b0;
    end else if (!ctrl_r[CTRL_SCAN]) begin
      // stale zone hits are dropped when scans stop
      pend_a_r <= 1'b0;
      pend_b_r <= 1'b0;
      if (dist_valid) begin
        alarm_a <= (dist_cm < dist_a_r);
        alarm_b <= (dist_cm < dist_b_r);
      end
    end else if (dist_valid) begin
      // the reading of the end cycle itself still counts toward this sweep
      if (sweep_end) begin
        alarm_a  <= pend_a_r || (accept && in_win(rep_ang, a_lo_r, a_hi_r)
                                 && dist_cm < dist_a_r);
        alarm_b  <= pend_b_r || (accept && in_win(rep_ang, b_lo_r, b_hi_r)
                                 && dist_cm < dist_b_r);
        pend_a_r <= 1'b0;
        pend_b_r <= 1'b0;
      end else begin
        if (accept && in_win(rep_ang, a_lo_r, a_hi_r) && dist_cm < dist_a_r)
          pend_a_r <= 1'b1;
        if (accept && in_win(rep_ang, b_lo_r, b_hi_r) && dist_cm < dist_b_r)
          pend_b_r <= 1'b1;
      end
    end
  end

  // reading report registers
  // angle and distance hold until the next accept
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      read_valid <= 1'b0;
      read_angle <= 16'h0000;
      read_dist  <= 16'h0000;
    end else begin
      read_valid <= accept;
      if (accept) begin
        read_angle <= rep_ang;
        read_dist  <= dist_cm;
      end
    end
  end

  // pwm frame: width latched once per frame so a pulse is never torn
  // limitation: a width past the frame is cut there
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_cnt_r <= 22'h000000;
      tick_cnt_r  <= 6'h00;
      hi_ticks_r  <= 16'h0000;
      width_r     <= 16'h0000;
      servo_pwm   <= 1'b0;
    end else if (frame_cnt_r == 22'(FRAME_CYC - 1)) begin
      frame_cnt_r <= 22'h000000;
      tick_cnt_r  <= 6'h00;
      hi_ticks_r  <= 16'h0000;
      width_r     <= (target_w > WIDTH_MAX_C) ? WIDTH_MAX_C : target_w;
      servo_pwm   <= 1'b0;
    end else begin
      frame_cnt_r <= frame_cnt_r + 22'h000001;
      if (tick_cnt_r == 6'(TICK_CYC - 1)) begin
        tick_cnt_r <= 6'h00;
        hi_ticks_r <= hi_ticks_r + 16'h0001;
      end else begin
        tick_cnt_r <= tick_cnt_r + 6'h01;
      end
      // 7 tenths of a us per tick: high while ticks*7 below width
      servo_pwm <= (32'(hi_ticks_r) * 7 < 32'(width_r));
    end
  end

  // settings written by software
  // unmapped or read-only offsets change nothing
  // nothing checks that the lower limit is below the upper
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r   <= 4'h0;
      min_w_r  <= servo_scan_pkg::MIN_W_RST;
      max_w_r  <= servo_scan_pkg::MAX_W_RST;
      scale_r  <= servo_scan_pkg::SCALE_RST;
      pos_r    <= 16'h0000;
      steps_r  <= servo_scan_pkg::STEPS_RST;
      lag_r    <= 16'h0000;
      fov_lo_r <= servo_scan_pkg::FOV_LO_RST;
      fov_hi_r <= servo_scan_pkg::FOV_HI_RST;
      a_lo_r   <= servo_scan_pkg::A_LO_RST;
      a_hi_r   <= servo_scan_pkg::A_HI_RST;
      b_lo_r   <= servo_scan_pkg::B_LO_RST;
      b_hi_r   <= servo_scan_pkg::B_HI_RST;
      dist_a_r <= servo_scan_pkg::DIST_A_RST;
      dist_b_r <= servo_scan_pkg::DIST_B_RST;
      irq_mask_r <= 3'h0;
    end else if (wr_en) begin
      case (paddr)
        servo_scan_pkg::CTRL_OFS:     ctrl_r   <= pwdata[3:0];
        servo_scan_pkg::MIN_W_OFS:    min_w_r  <= pwdata[15:0];
        servo_scan_pkg::MAX_W_OFS:    max_w_r  <= pwdata[15:0];
        servo_scan_pkg::SCALE_OFS:    scale_r  <= pwdata[15:0];
        servo_scan_pkg::POS_OFS:      pos_r    <= pwdata[15:0];
        servo_scan_pkg::STEPS_OFS:    steps_r  <= pwdata[15:0];
        servo_scan_pkg::LAG_OFS:      lag_r    <= pwdata[15:0];
        servo_scan_pkg::FOV_LO_OFS:   fov_lo_r <= pwdata[15:0];
        servo_scan_pkg::FOV_HI_OFS:   fov_hi_r <= pwdata[15:0];
        servo_scan_pkg::A_WIN_OFS: begin
          a_lo_r <= pwdata[15:0];
          a_hi_r <= pwdata[31:16];
        end
        servo_scan_pkg::B_WIN_OFS: begin
          b_lo_r <= pwdata[15:0];
          b_hi_r <= pwdata[31:16];
        end
        servo_scan_pkg::DIST_OFS: begin
          dist_a_r <= pwdata[15:0];
          dist_b_r <= pwdata[31:16];
        end
        servo_scan_pkg::IRQ_MASK_OFS: irq_mask_r <= pwdata[2:0];
        default: ;
      endcase
    end
  end

  // interrupt events and the write-one clear of this cycle
  always_comb begin
    hit_a = accept && in_win(rep_ang, a_lo_r, a_hi_r) && (dist_cm < dist_a_r);
    hit_b = accept && in_win(rep_ang, b_lo_r, b_hi_r) && (dist_cm < dist_b_r);
    // alarm event follows what this sweep end moves out
    ev    = {sweep_end && (pend_a_r || pend_b_r || hit_a || hit_b), sweep_end, accept};
    clr   = (wr_en && paddr == servo_scan_pkg::IRQ_ST_OFS) ? pwdata[2:0] : 3'h0;
  end

  // sticky interrupt status, a set in the clear cycle wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_st_r <= 3'h0;
      irq      <= 1'b0;
    end else begin
      irq_st_r <= (irq_st_r & ~clr) | ev;
      irq      <= |(((irq_st_r & ~clr) | ev) & irq_mask_r);
    end
  end

  // apb read data and answer, unmapped reads zero with pslverr
  // data fetched at setup stands for the access cycle
  // pslverr marks offsets past the map or unaligned
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          servo_scan_pkg::CTRL_OFS:     prdata <= {28'h0, ctrl_r};
          servo_scan_pkg::STATUS_OFS:   prdata <= {27'h0, pend_b_r, pend_a_r, dir_r,
                                                   alarm_b, alarm_a};
          servo_scan_pkg::MIN_W_OFS:    prdata <= {16'h0, min_w_r};
          servo_scan_pkg::MAX_W_OFS:    prdata <= {16'h0, max_w_r};
          servo_scan_pkg::SCALE_OFS:    prdata <= {16'h0, scale_r};
          servo_scan_pkg::POS_OFS:      prdata <= {16'h0, pos_r};
          servo_scan_pkg::STEPS_OFS:    prdata <= {16'h0, steps_r};
          servo_scan_pkg::LAG_OFS:      prdata <= {16'h0, lag_r};
          servo_scan_pkg::FOV_LO_OFS:   prdata <= {16'h0, fov_lo_r};
          servo_scan_pkg::FOV_HI_OFS:   prdata <= {16'h0, fov_hi_r};
          servo_scan_pkg::A_WIN_OFS:    prdata <= {a_hi_r, a_lo_r};
          servo_scan_pkg::B_WIN_OFS:    prdata <= {b_hi_r, b_lo_r};
          servo_scan_pkg::DIST_OFS:     prdata <= {dist_b_r, dist_a_r};
          servo_scan_pkg::READ_OFS:     prdata <= {read_dist, read_angle};
          servo_scan_pkg::WIDTH_OFS:    prdata <= {16'h0, width_r};
          servo_scan_pkg::IRQ_ST_OFS:   prdata <= {29'h0, irq_st_r};
          servo_scan_pkg::IRQ_MASK_OFS: prdata <= {29'h0, irq_mask_r};
          default: begin
            prdata  <= 32'h00000000;
          end
        endcase
      end
      if (psel && !penable && paddr > servo_scan_pkg::IRQ_MASK_OFS) pslverr <= 1'b1;
      if (psel && !penable && paddr[1:0] != 2'b00) pslverr <= 1'b1;
    end
  end
endmodule

// >>> sim/servo_scan_pwm_alarms_asserts.sv
// Purpose: port level checks for the servo scan pwm and alarm block
// Assumes: one clock domain, async active-low reset
// Notes:   frame gap is checked as a multiple, since idle frames carry no pulse
`timescale 1ns/10ps
module servo_scan_pwm_alarms_asserts #(
  parameter int unsigned FRAME_CYC = 2000,
  parameter int unsigned TICK_CYC  = 28
) (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        dist_valid,
  input wire logic        servo_pwm,
  input wire logic        alarm_a,
  input wire logic        alarm_b,
  input wire logic        read_valid
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  logic        pwm_q_r; // pwm one cycle back
  logic        seen_r;  // first rise has no gap to judge
  logic [31:0] gap_r;   // cycles since the last rise
  logic [31:0] hi_r;    // high cycles of the current pulse
  // pulse edge tracking
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pwm_q_r <= 1'b0;
      seen_r  <= 1'b0;
      gap_r   <= 32'h0;
      hi_r    <= 32'h0;
    end else begin
      pwm_q_r <= servo_pwm;
      gap_r   <= (servo_pwm && !pwm_q_r) ? 32'h1 : gap_r + 32'h1;
      hi_r    <= servo_pwm ? hi_r + 32'h1 : 32'h0;
      seen_r  <= seen_r | (servo_pwm & ~pwm_q_r);
    end
  end
  ready_after_setup_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  ready_single_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  err_read_zero_a: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read not zero");
  alarm_a_cause_a: assert property ($changed(alarm_a) |->
    $past(dist_valid) || $past(dist_valid, 2) || $past(dist_valid, 3))
    else $error("alarm a moved without reading");
  alarm_b_cause_a: assert property ($changed(alarm_b) |->
    $past(dist_valid) || $past(dist_valid, 2) || $past(dist_valid, 3))
    else $error("alarm b moved without reading");
  read_valid_cause_a: assert property (read_valid |->
    $past(dist_valid) || $past(dist_valid, 2) || $past(dist_valid, 3))
    else $error("reading without distance");
  frame_period_a: assert property (
    servo_pwm && !pwm_q_r && seen_r |-> gap_r % FRAME_CYC == 0)
    else $error("pulse off frame grid");
  tick_width_a: assert property (
    !servo_pwm && pwm_q_r |-> hi_r % TICK_CYC == 0)
    else $error("pulse width off tick grid");
  cover property ($rose(alarm_a));
  cover property (read_valid);
  cover property (pslverr);
  cover property ($fell(servo_pwm));
endmodule

bind servo_scan_pwm_alarms servo_scan_pwm_alarms_asserts #(
  .FRAME_CYC(FRAME_CYC), .TICK_CYC(TICK_CYC)) u_chk (
  .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .dist_valid(dist_valid),
  .servo_pwm(servo_pwm), .alarm_a(alarm_a), .alarm_b(alarm_b),
  .read_valid(read_valid));

// >>> sim/servo_model.sv
// Purpose: behavioural servo on the pwm control line
// Assumes: the servo only listens and drives nothing back
// Notes:   reports last pulse width and rise to rise period in cycles
`timescale 1ns/10ps
module servo_model (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic servo_pwm,
  output int        width_cyc,
  output int        period_cyc,
  output int        n_pulses
);
  logic q_r;    // pwm one cycle back
  int   hi_cnt; // high cycles so far
  int   since;  // cycles since the last rise
  // decode each pulse as the servo's input stage would
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q_r        <= 1'b0;
      hi_cnt     <= 0;
      since      <= 0;
      width_cyc  <= 0;
      period_cyc <= 0;
      n_pulses   <= 0;
    end else begin
      q_r    <= servo_pwm;
      since  <= since + 1;
      hi_cnt <= hi_cnt + 1;
      // rise restarts both counts
      if (servo_pwm && !q_r) begin
        period_cyc <= since;
        since      <= 1;
        hi_cnt     <= 1;
      end
      // fall closes the pulse
      if (!servo_pwm && q_r) begin
        width_cyc <= hi_cnt;
        n_pulses  <= n_pulses + 1;
      end
    end
  end
endmodule

// >>> sim/servo_scan_pwm_alarms_bench.sv
// Purpose: self-checking bench for the servo scan pwm and alarm block
// Assumes: short frame so several pwm frames fit a short run
// Notes:   widths are whole 0.7 us ticks, so no rounding is involved
`timescale 1ns/10ps
module servo_scan_pwm_alarms_bench;
  localparam int unsigned FR = 2000; // shortened frame, 28-cycle ticks kept
  logic        clk, rst_n, psel, penable, pwrite, dist_valid, er, fov_on;
  logic        pready, pslverr, servo_pwm, alarm_a, alarm_b, read_valid, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] dist_cm, read_angle, read_dist;
  logic [7:0]  ra [6];   // reset value addresses
  logic [15:0] rv [6];   // their reset values
  logic [15:0] dc [4];   // idle test distances
  int          n_errors, n_compared, width_cyc, period_cyc, n_pulses, n_rv, i, p;
  servo_scan_pwm_alarms #(.FRAME_CYC(FR), .TICK_CYC(28)) dut (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .dist_valid(dist_valid), .dist_cm(dist_cm),
    .servo_pwm(servo_pwm), .alarm_a(alarm_a), .alarm_b(alarm_b),
    .read_valid(read_valid), .read_angle(read_angle), .read_dist(read_dist), .irq(irq));
  servo_model sv (.clk(clk), .rst_n(rst_n), .servo_pwm(servo_pwm),
    .width_cyc(width_cyc), .period_cyc(period_cyc), .n_pulses(n_pulses));
  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one apb transfer, request held until ready is sampled
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge clk);
      t++;
    end while (pready !== 1'b1 && t < 50);
    chk("pready", 32'h1, {31'h0, pready});
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // one distance strobe, then time for the alarms to settle
  task automatic rdg(input logic [15:0] cm);
    @(posedge clk);
    dist_valid <= 1'b1;
    dist_cm    <= cm;
    @(posedge clk);
    dist_valid <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  // second whole pulse after a change carries the new width
  task automatic meas(input logic [31:0] cyc);
    p = n_pulses;
    for (i = 0; i < 4 * FR && n_pulses < p + 2; i++) @(posedge clk);
    chk("pwm width", cyc, width_cyc);
  endtask
  // feed readings until the sweep end flag shows
  task automatic sweep(input logic [15:0] cm);
    for (int k = 0; k < 40; k++) begin
      rdg(cm);
      apb(1'b0, servo_scan_pkg::IRQ_ST_OFS, 32'h0);
      if (rd[servo_scan_pkg::IRQ_SWEEP]) break;
    end
  endtask
  // accepted scan readings must lie inside the field of view
  always @(posedge clk) begin
    if (fov_on && read_valid === 1'b1) begin
      n_rv++;
      chk("fov angle sign", 32'h0, {31'h0, read_angle[15]});
    end
  end
  task automatic print_verdict;
    if (n_errors == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // watchdog, about four times the expected run
  initial begin
    repeat (80000) @(posedge clk);
    n_errors++;
    print_verdict();
  end
  initial begin
    {rst_n, psel, penable, pwrite, dist_valid, fov_on} = 6'h0;
    {paddr, pwdata, dist_cm} = 56'h0;
    {n_errors, n_compared, n_rv} = 0;
    ra = '{servo_scan_pkg::MIN_W_OFS, servo_scan_pkg::MAX_W_OFS, servo_scan_pkg::SCALE_OFS,
           servo_scan_pkg::STEPS_OFS, servo_scan_pkg::FOV_LO_OFS, servo_scan_pkg::FOV_HI_OFS};
    rv = '{16'h2710, 16'h4e20, 16'h0064, 16'h0004, 16'hf8f8, 16'h0708};
    dc = '{16'h0050, 16'h0028, 16'h00c8, 16'h0064};
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    for (int k = 0; k < 6; k++) begin
      apb(1'b0, ra[k], 32'h0);
      chk("reset value", {16'h0, rv[k]}, {16'h0, rd[15:0]});
    end
    apb(1'b0, 8'h44, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, er});
    chk("unmapped data", 32'h0, rd);
    // limits 7.0 and 21.0 us, scale 1.4 us per degree
    apb(1'b1, servo_scan_pkg::MIN_W_OFS, 32'h46);
    apb(1'b1, servo_scan_pkg::MAX_W_OFS, 32'hd2);
    apb(1'b1, servo_scan_pkg::SCALE_OFS, 32'h0e);
    apb(1'b1, servo_scan_pkg::POS_OFS, 32'h23);
    p = n_pulses;
    repeat (2 * FR) @(posedge clk);
    chk("pulses while disconnected", p, n_pulses);
    apb(1'b1, servo_scan_pkg::CTRL_OFS, 32'h9);
    meas(560);
    chk("pwm period", FR, period_cyc);
    apb(1'b1, servo_scan_pkg::CTRL_OFS, 32'h1);
    meas(756);
    apb(1'b1, servo_scan_pkg::POS_OFS, 32'hc8);
    meas(840);
    apb(1'b1, servo_scan_pkg::POS_OFS, 32'hff38);
    meas(280);
    apb(1'b0, servo_scan_pkg::WIDTH_OFS, 32'h0);
    chk("width reg", 32'h46, rd);
    // idle alarms: A at 100 cm, B at 50 cm, boundary is not shorter
    apb(1'b1, servo_scan_pkg::DIST_OFS, 32'h0032_0064);
    for (int k = 0; k < 4; k++) begin
      rdg(dc[k]);
      chk("idle alarm a", {31'h0, dc[k] < 16'd100}, {31'h0, alarm_a});
      chk("idle alarm b", {31'h0, dc[k] < 16'd50}, {31'h0, alarm_b});
    end
    // scan: A window covers all, B window lies beyond the sweep
    apb(1'b1, servo_scan_pkg::A_WIN_OFS, 32'h0708_f8f8);
    apb(1'b1, servo_scan_pkg::B_WIN_OFS, 32'h00c8_0064);
    apb(1'b1, servo_scan_pkg::IRQ_MASK_OFS, 32'h2);
    apb(1'b1, servo_scan_pkg::CTRL_OFS, 32'h3);
    sweep(16'd300);
    apb(1'b1, servo_scan_pkg::IRQ_ST_OFS, 32'h2);
    rdg(16'd10);
    chk("alarm a held", 32'h0, {31'h0, alarm_a});
    sweep(16'd10);
    chk("sweep irq", 32'h1, {31'h0, irq});
    chk("scan alarm a", 32'h1, {31'h0, alarm_a});
    chk("scan alarm b", 32'h0, {31'h0, alarm_b});
    chk("irq status", 32'h7, rd);
    apb(1'b1, servo_scan_pkg::IRQ_ST_OFS, 32'h2);
    repeat (2) @(posedge clk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    // crop the field of view to positive angles
    apb(1'b1, servo_scan_pkg::FOV_LO_OFS, 32'h0);
    fov_on = 1'b1;
    sweep(16'd300);
    sweep(16'd300);
    fov_on = 1'b0;
    chk("readings kept", 32'h1, {31'h0, n_rv > 0});
    // uni scan, 2.0 deg lag: each sweep end restarts at -5.0 deg
    apb(1'b1, servo_scan_pkg::FOV_LO_OFS, 32'hf8f8);
    apb(1'b1, servo_scan_pkg::LAG_OFS, 32'h14);
    apb(1'b1, servo_scan_pkg::CTRL_OFS, 32'h7);
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, servo_scan_pkg::IRQ_ST_OFS, 32'h2);
      sweep(16'd77);
      rdg(16'd77);
      chk("uni start angle", 32'hffba, {16'h0, read_angle});
      chk("reading distance", 32'h4d, {16'h0, read_dist});
    end
    print_verdict();
  end
endmodule
